// >>> pot_slave_consts.vh
// Constants for the dual potentiometer I2C slave
`ifndef POT_SLAVE_CONSTS_VH
`define POT_SLAVE_CONSTS_VH
`define ADDR_FIXED_HI 4'ha
`define REG_WIPER0 8'hf8
`define REG_WIPER1 8'hf9
`define REG_WIPER_BOTH 8'hfa
`define REG_GAIN 8'hfb
`define WIPER_RESET 6'h1f
`define GAIN_RESET 8'h11
`define GAIN_FIRST_RESET 3'h1
`define GAIN_SECOND_RESET 3'h1
`define GAIN_MASK 8'h77
`define NV_COMMIT_TIME_MS 20
`define CLK_HZ 10000000
`define NV_COMMIT_CYCLES (`NV_COMMIT_TIME_MS * (`CLK_HZ / 1000))
`endif

// >>> pot_i2c_slave.v
// I2C slave front end of a dual digital potentiometer with gain buffers
//
// Overview of operation
// - Low three slave address bits come from the three strap pins.
// - Address byte bit 0 selects write (0) or read (1).
// - Address mismatch: ignore bus until the next start.
// - First byte after a write address is the memory address.
// - Live setting updates at data ack; commit starts only after stop.
// - Repeated start ends write without nonvolatile commit.
// - Further data bytes overwrite the same register; pointer holds.
// - During commit time the device does not ack its address.
// - Reads return the register under the address pointer.
// - Dummy write sets pointer, then repeated start and read.
// - F8h/F9h wipers read/write, FAh sets both, low six bits, default 1Fh.
// - FBh holds both gains by nibble, reserved bits zero, default 11h.
// - Write-lock pin high blocks setting and commit changes; reads allowed.
`timescale 1ns/1ns
`include "pot_slave_consts.vh"
module pot_i2c_slave #(
  parameter NV_CYCLES = `NV_COMMIT_CYCLES
) (
  input wire clk_sys,
  input wire nrst,
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire addr_strap_bit0,
  input wire addr_strap_bit1,
  input wire addr_strap_bit2,
  input wire write_lock,
  output reg [5:0] wiper_first,
  output reg [5:0] wiper_second,
  output reg [2:0] gain_amp_first,
  output reg [2:0] gain_amp_second,
  output reg nv_commit_busy
);
  // -------------------------------------------------
  // State codes
  // -------------------------------------------------
  localparam ST_IDLE = 5'h01;
  localparam ST_RECV = 5'h02;
  localparam ST_ACK = 5'h04;
  localparam ST_SEND = 5'h08;
  localparam ST_MACK = 5'h10;

  // -------------------------------------------------
  // Input synchronisers
  // -------------------------------------------------
  reg [1:0] scl_sync;
  reg [1:0] sda_sync;
  reg [1:0] strap_sync0;
  reg [1:0] strap_sync1;
  reg [1:0] strap_sync2;
  reg [1:0] lock_sync;
  reg scl_d;
  reg sda_d;
  // Two flops on every pin, then one delay stage on scl and sda for edge finding
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      strap_sync0 <= 2'h0;
      strap_sync1 <= 2'h0;
      strap_sync2 <= 2'h0;
      lock_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl};
      sda_sync <= {sda_sync[0], sda_in};
      strap_sync0 <= {strap_sync0[0], addr_strap_bit0};
      strap_sync1 <= {strap_sync1[0], addr_strap_bit1};
      strap_sync2 <= {strap_sync2[0], addr_strap_bit2};
      lock_sync <= {lock_sync[0], write_lock};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  // Bus events seen on the synchronised lines
  wire scl_rise = scl_sync[1] & ~scl_d;
  wire scl_fall = ~scl_sync[1] & scl_d;
  wire start_det = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  wire stop_det = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
  wire [6:0] own_addr = {`ADDR_FIXED_HI, strap_sync2[1], strap_sync1[1], strap_sync0[1]};
  wire locked = lock_sync[1];

  // -------------------------------------------------
  // Protocol state
  // -------------------------------------------------
  reg [4:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [1:0] byte_idx; // 0 address, 1 memory address, 2 data
  reg read_dir;
  reg [7:0] pointer;
  reg data_written;
  reg [31:0] nv_cnt;

  // Register readback, reserved and unmapped bits read as zero
  reg [7:0] read_val;
  always @* begin
    case (pointer)
      `REG_WIPER0: read_val = {2'h0, wiper_first};
      `REG_WIPER1: read_val = {2'h0, wiper_second};
      `REG_GAIN: read_val = {1'b0, gain_amp_second, 1'b0, gain_amp_first};
      default: read_val = 8'h00;
    endcase
  end

  // Main bus sequencer
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      byte_idx <= 2'h0;
      read_dir <= 1'b0;
      pointer <= `REG_WIPER0;
      data_written <= 1'b0;
      nv_cnt <= 32'h0;
      nv_commit_busy <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wiper_first <= `WIPER_RESET;
      wiper_second <= `WIPER_RESET;
      gain_amp_first <= `GAIN_FIRST_RESET;
      gain_amp_second <= `GAIN_SECOND_RESET;
    end else begin
      // Commit timer runs independent of bus traffic
      if (nv_commit_busy) begin
        if (nv_cnt == 32'h1) begin
          nv_commit_busy <= 1'b0;
        end
        nv_cnt <= nv_cnt - 32'h1;
      end
      if (start_det) begin
        state <= ST_RECV;
        bit_cnt <= 4'h0;
        byte_idx <= 2'h0;
        data_written <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop_det) begin
        if (data_written && !locked) begin
          nv_commit_busy <= 1'b1;
          nv_cnt <= NV_CYCLES;
        end
        data_written <= 1'b0;
        state <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_RECV: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_sync[1]};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              bit_cnt <= 4'h0;
              state <= ST_ACK;
              sda_out <= 1'b0;
              sda_oe <= 1'b1;
              if (byte_idx == 2'h0) begin
                read_dir <= shift[0];
                if (shift[7:1] != own_addr || nv_commit_busy) begin
                  sda_oe <= 1'b0;
                  state <= ST_IDLE;
                end
              end else if (byte_idx == 2'h1) begin
                pointer <= shift;
              end else if (!locked) begin
                // lock blocks, live update, same register
                data_written <= 1'b1;
                case (pointer)
                  `REG_WIPER0: wiper_first <= shift[5:0];
                  `REG_WIPER1: wiper_second <= shift[5:0];
                  `REG_WIPER_BOTH: begin
                    wiper_first <= shift[5:0];
                    wiper_second <= shift[5:0];
                  end
                  `REG_GAIN: begin
                    gain_amp_first <= shift[2:0];
                    gain_amp_second <= shift[6:4];
                  end
                  default: data_written <= 1'b0;
                endcase
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (read_dir) begin
                state <= ST_SEND;
                shift <= {read_val[6:0], 1'b0};
                sda_oe <= ~read_val[7];
                sda_out <= 1'b0;
                bit_cnt <= 4'h1;
              end else begin
                state <= ST_RECV;
                sda_oe <= 1'b0;
                if (byte_idx != 2'h2) begin
                  byte_idx <= byte_idx + 2'h1;
                end
              end
            end
          end
          ST_SEND: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                state <= ST_MACK;
                sda_oe <= 1'b0;
              end else begin
                sda_oe <= ~shift[7];
                shift <= {shift[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_MACK: begin
            // Master ack continues the read, nack releases the bus
            if (scl_rise) begin
              if (sda_sync[1]) begin
                state <= ST_IDLE;
              end else begin
                state <= ST_ACK;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // pot_i2c_slave

// >>> pot_slave_monitor.sv
// Port checker for the potentiometer I2C slave
`timescale 1ns/1ns
module pot_slave_monitor #(
  parameter NV_CYCLES = 200000
) (
  input wire clk_sys,
  input wire nrst,
  input wire scl,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire write_lock,
  input wire [5:0] wiper_first,
  input wire [5:0] wiper_second,
  input wire [2:0] gain_amp_first,
  input wire [2:0] gain_amp_second,
  input wire nv_commit_busy
);
  reg [31:0] busy_cnt;
  wire [17:0] live = {wiper_first, wiper_second, gain_amp_first, gain_amp_second};
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  // Counts how long the commit flag has stood
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      busy_cnt <= 32'h0;
    else
      busy_cnt <= nv_commit_busy ? busy_cnt + 32'h1 : 32'h0;
  end
  property p_rst_val; $rose(nrst) |-> live == {6'h1f, 6'h1f, 3'h1, 3'h1}; endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad reset value");
  property p_upd_ack; $changed(live) |-> sda_oe && !scl; endproperty
  a_upd_ack: assert property (p_upd_ack) else $error("update off ack");
  property p_commit_stop; $rose(nv_commit_busy) |-> scl && sda_in; endproperty
  a_commit_stop: assert property (p_commit_stop) else $error("commit not at stop");
  property p_busy_len; $fell(nv_commit_busy) |-> busy_cnt >= NV_CYCLES && busy_cnt <= NV_CYCLES + 1; endproperty
  a_busy_len: assert property (p_busy_len) else $error("commit length");
  property p_busy_nack; nv_commit_busy |-> !$rose(sda_oe); endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("ack while busy");
  property p_oe_scl; $changed(sda_oe) |-> !scl; endproperty
  a_oe_scl: assert property (p_oe_scl) else $error("sda moved with scl high");
  property p_od; sda_oe |-> !sda_out; endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  property p_lock; write_lock[*4] |-> $stable(live) && !$rose(nv_commit_busy); endproperty
  a_lock: assert property (p_lock) else $error("change while locked");
endmodule // pot_slave_monitor
bind pot_i2c_slave pot_slave_monitor #(.NV_CYCLES(NV_CYCLES)) mon (.clk_sys(clk_sys), .nrst(nrst), .scl(scl),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .write_lock(write_lock), .wiper_first(wiper_first),
  .wiper_second(wiper_second), .gain_amp_first(gain_amp_first), .gain_amp_second(gain_amp_second),
  .nv_commit_busy(nv_commit_busy));

// >>> pot_bus_master.sv
// Behavioural I2C bus master facing the slave
`timescale 1ns/1ns
module pot_bus_master (
  input wire sda,
  output reg scl,
  output reg sda_low
);
  reg b;
  integer i;
  // Idle bus: clock parked high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One bit slot: data moves late in low phase, 100 ns before scl rises, sampled 200 ns into the high phase
  task bit_io(input v, output r);
    begin
      #400 sda_low = !v;
      #100 scl = 1'b1;
      #200 r = sda;
      #100 scl = 1'b0;
    end
  endtask
  // Byte MSB first, then answer slot
  task byte_io(input [7:0] d, input a, output [7:0] r, output ak);
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_io(d[i], b);
        r[i] = b;
      end
      bit_io(a, ak);
    end
  endtask
  task start;
    begin
      #400 sda_low = 1'b0;
      #100 scl = 1'b1;
      #300 sda_low = 1'b1;
      #400 scl = 1'b0;
    end
  endtask
  task stop;
    begin
      #400 sda_low = 1'b1;
      #100 scl = 1'b1;
      #300 sda_low = 1'b0;
    end
  endtask
endmodule // pot_bus_master

// >>> pot_i2c_slave_tb_top.sv
// Self-checking bench for the potentiometer I2C slave
`timescale 1ns/1ns
module pot_i2c_slave_tb_top;
  reg clk_sys = 1'b0;
  reg nrst = 1'b0;
  reg write_lock = 1'b0;
  reg [2:0] strap = 3'h0;
  wire scl, sda_low, sda_out, sda_oe, busy;
  wire [5:0] w0, w1;
  wire [2:0] g0, g1;
  wire sda = !(sda_low || sda_oe);
  integer mismatches = 0;
  integer checks_done = 0;
  integer i;
  integer seed = 32'hdd8e;
  reg [7:0] q[$];
  reg [7:0] seen, rd, d, e;
  reg [31:0] r32;
  reg ak;
  string nm;
  event obs;
  pot_i2c_slave #(.NV_CYCLES(200)) dut (.clk_sys(clk_sys), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .write_lock(write_lock), .wiper_first(w0), .wiper_second(w1), .gain_amp_first(g0), .gain_amp_second(g1),
    .nv_commit_busy(busy));
  pot_bus_master mst (.sda(sda), .scl(scl), .sda_low(sda_low));
  task stop_test;
    begin
      if (mismatches == 0 && checks_done > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task cmp(input string n, input [7:0] s, input [7:0] x);
    begin
      checks_done = checks_done + 1;
      if (s !== x) begin
        mismatches = mismatches + 1;
        $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
    end
  endtask
  // Notes the expectation and hands the observation over
  task put(input string n, input [7:0] s, input [7:0] x);
    begin
      q.push_back(x);
      nm = n;
      seen = s;
      -> obs;
      #1;
    end
  endtask
  task adr(input rw, input [7:0] x);
    begin
      mst.start;
      mst.byte_io({4'ha, strap, rw}, 1'b1, rd, ak);
      put("addr ack", {7'h0, ak}, x);
    end
  endtask
  task wb(input [7:0] v);
    begin
      mst.byte_io(v, 1'b1, rd, ak);
      put("data ack", {7'h0, ak}, 8'h00);
    end
  endtask
  task rdb(input [7:0] x);
    begin
      mst.byte_io(8'hff, 1'b1, rd, ak);
      put("read data", rd, x);
    end
  endtask
  task fin(input [7:0] x);
    begin
      mst.stop;
      repeat (6) @(posedge clk_sys);
      put("commit busy", {7'h0, busy}, x);
    end
  endtask
  // Clock
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // Watcher: oldest note against each observation
  initial begin
    forever begin
      @(obs);
      cmp(nm, seen, q.pop_front());
    end
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    r32 = $random(seed);
    d = r32[7:0];
    strap <= d[2:0];
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    put("gains", {1'b0, g1, 1'b0, g0}, 8'h11);
    mst.start;
    mst.byte_io({4'ha, ~strap, 1'b0}, 1'b1, rd, ak);
    put("foreign ack", {7'h0, ak}, 8'h01);
    mst.byte_io(8'hf9, 1'b1, rd, ak);
    put("ignored ack", {7'h0, ak}, 8'h01);
    adr(1'b0, 8'h00);
    wb(8'hf8);
    r32 = $random(seed);
    d = r32[7:0];
    wb(d);
    put("wiper_first", {2'h0, w0}, {2'h0, d[5:0]});
    r32 = $random(seed);
    e = r32[7:0];
    wb(e);
    put("wiper_first", {2'h0, w0}, {2'h0, e[5:0]});
    adr(1'b1, 8'h00);
    rdb({2'h0, e[5:0]});
    fin(8'h00);
    adr(1'b0, 8'h00);
    wb(8'hfb);
    r32 = $random(seed);
    d = r32[7:0];
    wb(d);
    e = d & 8'h77;
    put("gains", {1'b0, g1, 1'b0, g0}, e);
    fin(8'h01);
    adr(1'b0, 8'h01);
    mst.stop;
    for (i = 0; i < 400 && busy !== 1'b0; i = i + 1)
      @(posedge clk_sys);
    put("busy end", {7'h0, busy}, 8'h00);
    if (i == 400)
      stop_test;
    adr(1'b0, 8'h00);
    wb(8'hfb);
    adr(1'b1, 8'h00);
    rdb(e);
    adr(1'b0, 8'h00);
    wb(8'hfa);
    r32 = $random(seed);
    d = r32[7:0];
    wb(d);
    put("wiper_first", {2'h0, w0}, {2'h0, d[5:0]});
    put("wiper_second", {2'h0, w1}, {2'h0, d[5:0]});
    adr(1'b1, 8'h00);
    rdb(8'h00);
    fin(8'h00);
    @(posedge clk_sys);
    write_lock <= 1'b1;
    repeat (4) @(posedge clk_sys);
    adr(1'b0, 8'h00);
    wb(8'hf9);
    wb(~d);
    put("wiper_second", {2'h0, w1}, {2'h0, d[5:0]});
    fin(8'h00);
    adr(1'b0, 8'h00);
    wb(8'hf9);
    adr(1'b1, 8'h00);
    rdb({2'h0, d[5:0]});
    mst.stop;
    stop_test;
  end
endmodule // pot_i2c_slave_tb_top
